// ===== src/ddr3_command_decoder.v
`include "ddr_cmd_map.vh"
module ddr3_command_decoder #(
  parameter ROW_W  = 14,
  parameter COL_W  = 10,
  parameter DQ_W   = 8,
  parameter BANKS  = 8
) (
  input  wire                 core_clk,
  input  wire                 reset,
  input  wire                 chip_select_n,
  input  wire                 row_strobe_n,
  input  wire                 col_strobe_n,
  input  wire                 write_enable_n,
  input  wire                 clock_enable,
  input  wire [2:0]           bank_addr,
  input  wire [ROW_W-1:0]     addr,
  input  wire                 write_data_mask,
  input  wire [DQ_W-1:0]      write_data,
  input  wire                 chop_per_command,
  input  wire                 fixed_chop,
  output reg  [3:0]           op_code,
  output reg                  op_valid,
  output reg  [2:0]           op_bank,
  output reg  [ROW_W-1:0]     op_row,
  output reg  [COL_W-1:0]     op_col,
  output reg                  op_auto_close,
  output reg  [3:0]           op_beats,
  output reg  [BANKS-1:0]     bank_open,
  output wire                 device_idle,
  output reg                  power_down,
  output reg                  self_refresh,
  output wire                 wr_valid,
  input  wire                 wr_ready,
  output wire [DQ_W-1:0]      wr_data,
  output wire [COL_W-1:0]     wr_col,
  output wire [2:0]           wr_bank,
  output wire                 data_ready
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg  [3:0]       cmd_s1_r;
reg  [3:0]       cmd_s2_r;
reg              cke_s1_r;
reg              cke_s2_r;
reg  [2:0]       ba_s1_r;
reg  [2:0]       ba_s2_r;
reg  [ROW_W-1:0] a_s1_r;
reg  [ROW_W-1:0] a_s2_r;
reg              dm_s1_r;
reg              dm_s2_r;
reg  [DQ_W-1:0]  dq_s1_r;
reg  [DQ_W-1:0]  dq_s2_r;
reg              cke_prev_r;

always @(posedge core_clk) begin
  if (reset) begin
    cmd_s1_r   <= 4'hf;
    cmd_s2_r   <= 4'hf;
    cke_s1_r   <= 1'b0;
    cke_s2_r   <= 1'b0;
    ba_s1_r    <= 3'h0;
    ba_s2_r    <= 3'h0;
    a_s1_r     <= {ROW_W{1'b0}};
    a_s2_r     <= {ROW_W{1'b0}};
    dm_s1_r    <= 1'b1;
    dm_s2_r    <= 1'b1;
    dq_s1_r    <= {DQ_W{1'b0}};
    dq_s2_r    <= {DQ_W{1'b0}};
    cke_prev_r <= 1'b0;
  end else begin
    cmd_s1_r   <= {chip_select_n, row_strobe_n, col_strobe_n,
                   write_enable_n};
    cmd_s2_r   <= cmd_s1_r;
    cke_s1_r   <= clock_enable;
    cke_s2_r   <= cke_s1_r;
    ba_s1_r    <= bank_addr;
    ba_s2_r    <= ba_s1_r;
    a_s1_r     <= addr;
    a_s2_r     <= a_s1_r;
    dm_s1_r    <= write_data_mask;
    dm_s2_r    <= dm_s1_r;
    dq_s1_r    <= write_data;
    dq_s2_r    <= dq_s1_r;
    cke_prev_r <= cke_s2_r;
  end
end

// ----------------------------------------
// Command decode
// ----------------------------------------
wire cur_cke  = cke_s2_r;
wire cke_hh   = cke_prev_r & cur_cke;
wire cke_fall = cke_prev_r & ~cur_cke;
wire cke_rise = ~cke_prev_r & cur_cke;
wire is_nop   = cmd_s2_r[3] | (cmd_s2_r[2:0] == 3'h7);

assign device_idle = (bank_open == {BANKS{1'b0}});
wire bank_act = bank_open[ba_s2_r];

reg  [3:0] dec_op;
reg  [3:0] burst_cnt_r;
reg  [3:0] burst_cnt_nxt;

always @* begin
  dec_op = `OP_NONE;
  if (power_down | self_refresh) begin
    if (cke_rise && is_nop)
      dec_op = self_refresh ? `OP_SR_EXIT : `OP_PD_EXIT;
  end else if (cke_fall) begin
    if (device_idle && is_nop)
      dec_op = `OP_PD_ENTER;
    else if (device_idle && cmd_s2_r == 4'h1)
      dec_op = `OP_SR_ENTER;
    else
      dec_op = `OP_ILLEGAL;
  end else if (cke_hh && !cmd_s2_r[3]) begin
    case (cmd_s2_r[2:0])
      3'h3: begin
        if (!bank_act)
          dec_op = `OP_ACTIVATE;
        else
          dec_op = `OP_ILLEGAL;
      end
      3'h5: begin
        if (bank_act)
          dec_op = `OP_READ;
        else
          dec_op = `OP_ILLEGAL;
      end
      3'h4: begin
        if (bank_act)
          dec_op = `OP_WRITE;
        else
          dec_op = `OP_ILLEGAL;
      end
      3'h2: begin
        if (a_s2_r[`AUTO_CLOSE_BIT])
          dec_op = `OP_PRECHARGE_ALL;
        else
          dec_op = `OP_PRECHARGE;
      end
      3'h1: begin
        if (device_idle)
          dec_op = `OP_REFRESH;
        else
          dec_op = `OP_ILLEGAL;
      end
      3'h0: begin
        if (device_idle && burst_cnt_r == 4'h0)
          dec_op = `OP_MODE_SET;
        else
          dec_op = `OP_ILLEGAL;
      end
      3'h6: begin
        if (!device_idle)
          dec_op = `OP_ILLEGAL;
        else if (a_s2_r[`AUTO_CLOSE_BIT])
          dec_op = `OP_ZQ_LONG;
        else
          dec_op = `OP_ZQ_SHORT;
      end
      default: dec_op = `OP_NONE;
    endcase
  end
end

wire is_rw   = (dec_op == `OP_READ) | (dec_op == `OP_WRITE);
wire chop    = chop_per_command ? ~a_s2_r[`BURST_CHOP_BIT]
                                : fixed_chop;
wire [3:0] beats = chop ? `BEATS_CHOP : `BEATS_FULL;

// ----------------------------------------
// Burst tracking
// ----------------------------------------
reg              wr_burst_r;
reg              close_pend_r;
reg  [2:0]       burst_bank_r;
reg  [COL_W-1:0] col_r;

always @* begin
  burst_cnt_nxt = burst_cnt_r;
  if (is_rw)
    burst_cnt_nxt = beats;
  else if (burst_cnt_r != 4'h0 && data_ready)
    burst_cnt_nxt = burst_cnt_r - 4'h1;
end

// ----------------------------------------
// Burst counter and column
// ----------------------------------------
wire burst_step = !is_rw && burst_cnt_r != 4'h0 && data_ready;
wire burst_end  = burst_step && burst_cnt_r == 4'h1;

always @(posedge core_clk) begin
  if (reset) begin
    burst_cnt_r  <= 4'h0;
    wr_burst_r   <= 1'b0;
    close_pend_r <= 1'b0;
    burst_bank_r <= 3'h0;
    col_r        <= {COL_W{1'b0}};
  end else begin
    burst_cnt_r <= burst_cnt_nxt;
    if (is_rw) begin
      col_r        <= a_s2_r[COL_W-1:0];
      burst_bank_r <= ba_s2_r;
      wr_burst_r   <= (dec_op == `OP_WRITE);
      close_pend_r <= a_s2_r[`AUTO_CLOSE_BIT];
    end else if (burst_step) begin
      col_r <= col_r + {{(COL_W-1){1'b0}}, 1'b1};
      if (burst_end) begin
        wr_burst_r   <= 1'b0;
        close_pend_r <= 1'b0;
      end
    end
  end
end

// ----------------------------------------
// Operation outputs
// ----------------------------------------
always @(posedge core_clk) begin
  if (reset) begin
    op_code       <= `OP_NONE;
    op_valid      <= 1'b0;
    op_bank       <= 3'h0;
    op_row        <= {ROW_W{1'b0}};
    op_col        <= {COL_W{1'b0}};
    op_auto_close <= 1'b0;
    op_beats      <= 4'h0;
  end else begin
    op_valid      <= (dec_op != `OP_NONE);
    op_code       <= dec_op;
    op_bank       <= ba_s2_r;
    op_row        <= a_s2_r;
    op_col        <= a_s2_r[COL_W-1:0];
    op_auto_close <= is_rw & a_s2_r[`AUTO_CLOSE_BIT];
    op_beats      <= is_rw ? beats : 4'h0;
  end
end

// ----------------------------------------
// Bank state
// ----------------------------------------
always @(posedge core_clk) begin
  if (reset) begin
    bank_open <= {BANKS{1'b0}};
  end else begin
    if (burst_end && close_pend_r)
      bank_open[burst_bank_r] <= 1'b0;
    case (dec_op)
      `OP_ACTIVATE:      bank_open[ba_s2_r] <= 1'b1;
      `OP_PRECHARGE:     bank_open[ba_s2_r] <= 1'b0;
      `OP_PRECHARGE_ALL: bank_open <= {BANKS{1'b0}};
      default:           ;
    endcase
  end
end

// ----------------------------------------
// Power state
// ----------------------------------------
always @(posedge core_clk) begin
  if (reset) begin
    power_down   <= 1'b0;
    self_refresh <= 1'b0;
  end else begin
    case (dec_op)
      `OP_PD_ENTER: power_down <= 1'b1;
      `OP_PD_EXIT:  power_down <= 1'b0;
      `OP_SR_ENTER: self_refresh <= 1'b1;
      `OP_SR_EXIT:  self_refresh <= 1'b0;
      default:      ;
    endcase
  end
end

// ----------------------------------------
// Two-entry write buffer
// ----------------------------------------
reg  [DQ_W+COL_W+2:0] buf_r [0:1];
reg                   rd_ptr_r;
reg                   wr_ptr_r;
reg  [1:0]            count_r;

wire beat_now = wr_burst_r & (burst_cnt_r != 4'h0);
wire keep     = beat_now & ~dm_s2_r;
assign data_ready = (count_r != 2'h2);
wire push = keep & data_ready;
wire pop  = wr_valid & wr_ready;

assign wr_valid = (count_r != 2'h0);
assign wr_data  = buf_r[rd_ptr_r][DQ_W+COL_W+2:COL_W+3];
assign wr_col   = buf_r[rd_ptr_r][COL_W+2:3];
assign wr_bank  = buf_r[rd_ptr_r][2:0];

always @(posedge core_clk) begin
  if (reset) begin
    rd_ptr_r <= 1'b0;
    wr_ptr_r <= 1'b0;
    count_r  <= 2'h0;
    buf_r[0] <= {(DQ_W+COL_W+3){1'b0}};
    buf_r[1] <= {(DQ_W+COL_W+3){1'b0}};
  end else begin
    if (push) begin
      buf_r[wr_ptr_r] <= {dq_s2_r, col_r, burst_bank_r};
      wr_ptr_r <= ~wr_ptr_r;
    end
    if (pop)
      rd_ptr_r <= ~rd_ptr_r;
    if (push & ~pop)
      count_r <= count_r + 2'h1;
    else if (pop & ~push)
      count_r <= count_r - 2'h1;
  end
end

endmodule // ddr3_command_decoder

// ===== include/ddr_cmd_map.vh
`ifndef DDR_CMD_MAP_VH
`define DDR_CMD_MAP_VH
// ----------------------------------------
// Field positions
// ----------------------------------------
`define AUTO_CLOSE_BIT      10
`define BURST_CHOP_BIT      12
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_NONE             4'h0
`define OP_ACTIVATE         4'h1
`define OP_READ             4'h2
`define OP_WRITE            4'h3
`define OP_PRECHARGE        4'h4
`define OP_PRECHARGE_ALL    4'h5
`define OP_REFRESH          4'h6
`define OP_MODE_SET         4'h7
`define OP_ZQ_LONG          4'h8
`define OP_ZQ_SHORT         4'h9
`define OP_PD_ENTER         4'ha
`define OP_PD_EXIT          4'hb
`define OP_SR_ENTER         4'hc
`define OP_SR_EXIT          4'hd
`define OP_ILLEGAL          4'hf
// ----------------------------------------
// Burst lengths and reset values
// ----------------------------------------
`define BEATS_FULL          4'h8
`define BEATS_CHOP          4'h4
`define RESET_MODE          2'h0
`endif

// ===== verification/ddr3_command_decoder_properties.sv
`include "ddr_cmd_map.vh"
module ddr3_command_decoder_checker #(
  parameter DQ_W  = 8,
  parameter BANKS = 8
) (
  input wire logic core_clk, reset, chip_select_n, row_strobe_n,
  input wire logic col_strobe_n, write_enable_n, clock_enable,
  input wire logic chop_per_command, fixed_chop, op_valid, device_idle,
  input wire logic power_down, self_refresh, wr_valid, wr_ready,
  input wire logic [3:0] op_code, op_beats,
  input wire logic [2:0] op_bank,
  input wire logic [BANKS-1:0] bank_open,
  input wire logic [DQ_W-1:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_cke_hh;
    clock_enable && $past(clock_enable);
  endsequence
  sequence s_rd;
    !chip_select_n && row_strobe_n && !col_strobe_n && write_enable_n;
  endsequence
  sequence s_wr;
    !chip_select_n && row_strobe_n && !col_strobe_n && !write_enable_n;
  endsequence
  sequence s_mrs;
    !chip_select_n && !row_strobe_n && !col_strobe_n && !write_enable_n;
  endsequence
  chk_read_answer: assert property (s_rd and s_cke_hh |-> ##3 op_valid &&
    (op_code == `OP_READ || op_code == `OP_ILLEGAL)) else $error("read");
  chk_write_answer: assert property (s_wr and s_cke_hh |-> ##3 op_valid &&
    (op_code == `OP_WRITE || op_code == `OP_ILLEGAL)) else $error("write");
  chk_mode_answer: assert property (s_mrs and s_cke_hh |-> ##3 op_valid &&
    (op_code == `OP_MODE_SET || op_code == `OP_ILLEGAL)) else $error("mrs");
  chk_pd_enter: assert property (op_valid && op_code == `OP_PD_ENTER
    |=> power_down) else $error("pd enter");
  chk_pd_leave: assert property (op_valid && op_code == `OP_PD_EXIT
    |=> !power_down) else $error("pd exit");
  chk_sr_leave: assert property (op_valid && op_code == `OP_SR_EXIT
    |=> !self_refresh && device_idle) else $error("sr exit");
  chk_idle_banks: assert property (device_idle == (bank_open == '0))
    else $error("idle");
  chk_act_opens: assert property (op_valid && op_code == `OP_ACTIVATE
    |=> bank_open[$past(op_bank)]) else $error("activate");
  chk_pre_all: assert property (op_valid && op_code == `OP_PRECHARGE_ALL
    |=> bank_open == '0) else $error("precharge all");
  chk_fixed_beats: assert property (op_valid && !chop_per_command &&
    (op_code == `OP_READ || op_code == `OP_WRITE) |->
    op_beats == (fixed_chop ? `BEATS_CHOP : `BEATS_FULL)) else $error("beats");
  chk_buf_hold: assert property (wr_valid && !wr_ready
    |=> wr_valid && $stable(wr_data)) else $error("buffer hold");
endmodule // ddr3_command_decoder_checker
bind ddr3_command_decoder ddr3_command_decoder_checker #(.DQ_W(DQ_W),
  .BANKS(BANKS)) u_chk(.core_clk, .reset, .chip_select_n, .row_strobe_n,
  .col_strobe_n, .write_enable_n, .clock_enable, .chop_per_command,
  .fixed_chop, .op_valid, .device_idle, .power_down, .self_refresh,
  .wr_valid, .wr_ready, .op_code, .op_beats, .op_bank, .bank_open, .wr_data);

// ===== verification/ddr3_wr_sink.sv
module ddr3_wr_sink (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        stall,
  input wire logic        wr_valid,
  input wire logic [7:0]  wr_data,
  output logic            wr_ready,
  output logic [15:0]     got_cnt,
  output logic [15:0]     got_sum
);
  timeunit 1ns;
  timeprecision 1ps;
  assign wr_ready = ~stall & ~reset;
  always @(posedge core_clk) begin
    if (reset) begin
      got_cnt <= 16'h0;
      got_sum <= 16'h0;
    end else if (wr_valid && wr_ready) begin
      got_cnt <= got_cnt + 16'h1;
      got_sum <= got_sum + {8'h0, wr_data};
    end
  end
endmodule // ddr3_wr_sink

// ===== verification/ddr3_command_decoder_tb_top.sv
`include "ddr_cmd_map.vh"
module ddr3_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, chip_select_n, row_strobe_n, col_strobe_n, stall;
  logic write_enable_n, clock_enable, write_data_mask, chop_per_command;
  logic fixed_chop, op_valid, op_auto_close, device_idle, power_down;
  logic self_refresh, wr_valid, wr_ready, data_ready;
  logic [2:0] bank_addr, op_bank, wr_bank;
  logic [13:0] addr, op_row;
  logic [9:0] op_col, wr_col;
  logic [7:0] write_data, wr_data, bank_open;
  logic [3:0] op_code, op_beats;
  logic [15:0] got_cnt, got_sum;
  int err_total, comparisons;
  ddr3_command_decoder u_dut(.core_clk, .reset, .chip_select_n,
    .row_strobe_n, .col_strobe_n, .write_enable_n, .clock_enable, .bank_addr,
    .addr, .write_data_mask, .write_data, .chop_per_command, .fixed_chop,
    .op_code, .op_valid, .op_bank, .op_row, .op_col, .op_auto_close,
    .op_beats, .bank_open, .device_idle, .power_down, .self_refresh,
    .wr_valid, .wr_ready, .wr_data, .wr_col, .wr_bank, .data_ready);
  ddr3_wr_sink u_sink(.core_clk, .reset, .stall, .wr_valid, .wr_data,
    .wr_ready, .got_cnt, .got_sum);
  task automatic finish_test(input bit late);
    if (late) err_total++;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pins(input logic [3:0] c, input logic k,
                      input logic [2:0] b, input logic [13:0] a);
    @(negedge core_clk);
    {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = c;
    clock_enable = k;
    bank_addr = b;
    addr = a;
  endtask
  task automatic op(input logic [3:0] c, input logic k, input logic [2:0] b,
                    input logic [13:0] a, input logic [3:0] exp);
    int n;
    pins(c, k, b, a);
    pins(4'h7, k, 3'h0, 14'h0);
    for (n = 0; n < 8 && op_valid !== 1'b1; n++) @(negedge core_clk);
    if (n == 8) finish_test(1'b1);
    chk({12'h0, op_code}, {12'h0, exp});
  endtask
  task automatic wait_for(input int sel);
    int n;
    for (n = 0; n < 40 && (sel ? wr_valid : data_ready) !== 1'b0; n++)
      @(negedge core_clk);
    if (n == 40) finish_test(1'b1);
  endtask
  task automatic t_banks;
    chop_per_command = 1'b1;
    op(4'h3, 1'b1, 3'h3, 14'h0123, `OP_ACTIVATE);
    op(4'h3, 1'b1, 3'h3, 14'h0123, `OP_ILLEGAL);
    op(4'h5, 1'b1, 3'h5, 14'h0008, `OP_ILLEGAL);
    op(4'h5, 1'b1, 3'h3, 14'h0408, `OP_READ);
    chk({12'h0, op_beats}, {12'h0, `BEATS_CHOP});
    chk({6'h0, op_col}, 16'h0008);
    chk({15'h0, op_auto_close}, 16'h1);
    repeat (16) @(negedge core_clk);
    chk({8'h0, bank_open}, 16'h0);
    $display("test banks done");
  endtask
  task automatic t_write(input logic s);
    chop_per_command = 1'b0;
    stall = s;
    op(4'h3, 1'b1, 3'h1, 14'h0, `OP_ACTIVATE);
    pins(4'h4, 1'b1, 3'h1, 14'h0010);
    for (int i = 0; i < 8; i++) begin
      pins(4'h7, 1'b1, 3'h0, 14'h0);
      write_data = 8'h10 + 8'(i);
      write_data_mask = !s && (i == 2 || i == 5);
    end
    repeat (6) @(negedge core_clk);
    if (s) begin
      wait_for(0);
      chk({15'h0, data_ready}, 16'h0);
      stall = 1'b0;
    end
    wait_for(1);
    if (!s) begin
      chk(got_cnt, 16'h6);
      chk(got_sum, 16'h0075);
    end
    chk({15'h0, bank_open[1]}, 16'h1);
    op(4'h2, 1'b1, 3'h1, 14'h0, `OP_PRECHARGE);
    chk({15'h0, bank_open[1]}, 16'h0);
    $display("test write done");
  endtask
  task automatic t_power;
    op(4'h2, 1'b1, 3'h0, 14'h0400, `OP_PRECHARGE_ALL);
    op(4'h1, 1'b1, 3'h0, 14'h0, `OP_REFRESH);
    op(4'h0, 1'b1, 3'h2, 14'h0, `OP_MODE_SET);
    op(4'h6, 1'b1, 3'h0, 14'h0400, `OP_ZQ_LONG);
    op(4'h6, 1'b1, 3'h0, 14'h0, `OP_ZQ_SHORT);
    op(4'h7, 1'b0, 3'h0, 14'h0, `OP_PD_ENTER);
    @(negedge core_clk);
    chk({15'h0, power_down}, 16'h1);
    op(4'h7, 1'b1, 3'h0, 14'h0, `OP_PD_EXIT);
    op(4'h1, 1'b0, 3'h0, 14'h0, `OP_SR_ENTER);
    @(negedge core_clk);
    chk({15'h0, self_refresh}, 16'h1);
    op(4'h7, 1'b1, 3'h0, 14'h0, `OP_SR_EXIT);
    $display("test power done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    {reset, chip_select_n, row_strobe_n, col_strobe_n} = 4'hf;
    {write_enable_n, clock_enable, stall, fixed_chop} = 4'hc;
    {bank_addr, addr, write_data, write_data_mask} = 26'h0;
    chop_per_command = 1'b0;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({7'h0, device_idle, bank_open}, 16'h0100);
    t_banks();
    t_write(1'b0);
    t_write(1'b1);
    t_power();
    finish_test(1'b0);
  end
endmodule // ddr3_command_decoder_tb_top
